// [rtl/ovrd_defines.svh]
// Offsets, field positions, reset values and counts of the overrange block.
// Assumes inclusion by bare name from the package and the design files.
`ifndef OVRD_DEFINES_SVH
`define OVRD_DEFINES_SVH

// -------------------------------------------------------------
// Register byte offsets
// -------------------------------------------------------------
`define OVRD_ADDR_CTRL 4'h0
`define OVRD_ADDR_STAT 4'h4
`define OVRD_ADDR_MASK 4'h8
`define OVRD_ADDR_FLAG 4'hC

// -------------------------------------------------------------
// Control fields and reset values
// -------------------------------------------------------------
`define OVRD_THR_HI_LSB 0
`define OVRD_THR_LO_LSB 8
`define OVRD_PER_LSB 16
`define OVRD_MODE_LSB 20
`define OVRD_THR_HI_RST 8'hE4
`define OVRD_THR_LO_RST 8'h40
`define OVRD_PER_RST 3'h0
`define OVRD_MODE_RST 2'h0
`define OVRD_MODE_REAL 2'h1
`define OVRD_MODE_CPLX 2'h2

// -------------------------------------------------------------
// Data path figures
// -------------------------------------------------------------
`define OVRD_NEG_FULL 12'h800
`define OVRD_MAG_SAT 8'hFF
`define OVRD_PULSE_BASE 11'h008
`define OVRD_CNT_W 11
`define OVRD_WIN_W 9
`define OVRD_WIN_ONE 9'h001
`define OVRD_NFLAG 4

`endif

// [rtl/ovrd_pkg.sv]
// Types of the overrange detector: module state records.
// Assumes ovrd_defines.svh on the include path.
`include "ovrd_defines.svh"

package ovrd_pkg;

	// -------------------------------------------------------------
	// Pulse stretcher state
	// -------------------------------------------------------------
	typedef struct packed {
		logic [`OVRD_CNT_W-1:0] cnt;
		logic flag;
	} ovrd_str_st_t;

	// -------------------------------------------------------------
	// Main block state
	// -------------------------------------------------------------
	typedef struct packed {
		logic [7:0] thr_hi;
		logic [7:0] thr_lo;
		logic [2:0] per;
		logic [1:0] mode;
		logic [`OVRD_NFLAG-1:0] status;
		logic [`OVRD_NFLAG-1:0] mask;
		logic irq;
		logic rdy;
		logic resp;
		logic [31:0] hrdata;
		logic ap_wr;
		logic [3:0] ap_addr;
		logic [`OVRD_WIN_W-1:0] win_cnt;
		logic [`OVRD_NFLAG-1:0] acc;
		logic [`OVRD_NFLAG-1:0] emb;
		logic phase;
		logic [15:0] dec_a;
		logic [15:0] dec_b;
		logic dec_v;
	} ovrd_st_t;

endpackage

// [rtl/ovrd_stretch.sv]
// Pulse stretcher for one overrange status output.
// Assumes hit is a same-clock one-cycle qualifying-sample strobe.
`timescale 1ns/1ps
`default_nettype none
`include "ovrd_defines.svh"

module ovrd_stretch
	import ovrd_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic hit,
	input wire logic [2:0] per_sel,
	output logic flag
);

	// -------------------------------------------------------------
	// Hold length
	// -------------------------------------------------------------
	function automatic logic [`OVRD_CNT_W-1:0] hold_len(
		input logic [2:0] sel);
		hold_len = `OVRD_PULSE_BASE << sel;
	endfunction

	ovrd_str_st_t st_r;
	ovrd_str_st_t st_nxt;

	// -------------------------------------------------------------
	// Counter
	// -------------------------------------------------------------
	always_comb
	begin
		st_nxt = st_r;
		if (hit)
		begin
			// Restart from the latest event [R16] [R10]
			st_nxt.flag = 1'b1;
			st_nxt.cnt = hold_len(per_sel) - `OVRD_CNT_W'(1);
		end
		else if (st_r.cnt != '0)
			st_nxt.cnt = st_r.cnt - `OVRD_CNT_W'(1);
		else
			st_nxt.flag = 1'b0;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign flag = st_r.flag;

	// -------------------------------------------------------------
	// Checks
	// -------------------------------------------------------------
	property p_restart;
		@(posedge clk) disable iff (!nrst)
		hit |=> flag;
	endproperty
	a_restart: assert property (p_restart) // [R16]
		else $error("flag not raised after hit");

	property p_len8;
		@(posedge clk) disable iff (!nrst)
		(hit && per_sel == 3'h0) ##1 (!hit && per_sel == 3'h0)[*8]
			|-> flag ##1 !flag;
	endproperty
	a_len8: assert property (p_len8) // [R10]
		else $error("pulse length at setting zero not eight");

endmodule
`default_nettype wire

// [rtl/ovrd_top.sv]
// Overrange detector: thresholds, stretched status pins, embedded flags.
// Assumes an AHB-Lite master on CLK_SYS and converter samples on the same
// clock; sample strobes come from on-chip logic, so no synchroniser.
//
// Operation
// R1: Samples are 12-bit two's complement, -2048 to +2047.
// R2: Negative input difference gives negative two's-complement codes.
// R3: Absolute value, upper 8 bits compared with high and low thresholds.
// R4: Both channels share the same threshold pair.
// R5: Magnitude saturates; -2048 gives 2047, compare value 255.
// R6: -2032 gives magnitude 2032, compare value 254, same as +2032.
// R7: Flag is 1 when magnitude reaches or exceeds its threshold.
// R8: Channel A and channel B each drive their own high and low pins.
// R9: Single-channel monitor ORs both high pins and both low pins.
// R10: Pin pulse lasts 8 cycles at setting 0, doubling to 1024.
// R11: Flags embedded in sample LSB only in decimating modes.
// R12: Complex modes: high flag in I LSB, low flag in Q LSB.
// R13: Real mode: high flag in even samples, low flag in odd.
// R14: Embedded bit high if threshold reached within monitoring period.
// R15: Period is 2^(n+1) samples real, 2^n samples complex.
// R16: Every sample checked; a new hit restarts the pulse counter.
// R17: High and low comparisons run separately with own counters.
//
// Chosen here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "ovrd_defines.svh"

module ovrd_top
	import ovrd_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic NRST,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic HREADYOUT,
	output logic HRESP,
	output logic [31:0] HRDATA,
	input wire logic [11:0] SAMPLE_A,
	input wire logic [11:0] SAMPLE_B,
	input wire logic SAMPLE_VALID,
	input wire logic [15:0] DEC_A_IN,
	input wire logic [15:0] DEC_B_IN,
	input wire logic DEC_VALID_IN,
	output logic [15:0] DEC_A_OUT,
	output logic [15:0] DEC_B_OUT,
	output logic DEC_VALID_OUT,
	output logic CHAN_A_HIGH_FLAG_OUT,
	output logic CHAN_A_LOW_FLAG_OUT,
	output logic CHAN_B_HIGH_FLAG_OUT,
	output logic CHAN_B_LOW_FLAG_OUT,
	output logic IRQ
);

	// -------------------------------------------------------------
	// Functions
	// -------------------------------------------------------------
	// Saturating magnitude, upper eight of eleven bits
	function automatic logic [7:0] abs_mag(input logic [11:0] s);
		logic [11:0] m;
		m = '0;
		if (s == `OVRD_NEG_FULL)
			abs_mag = `OVRD_MAG_SAT; // [R5]
		else
		begin
			// Sign bit marks a negative code [R1] [R2]
			m = s[11] ? 12'(-s) : s;
			abs_mag = m[10:3]; // [R3] [R6]
		end
	endfunction

	// Samples per monitoring window
	function automatic logic [`OVRD_WIN_W-1:0] win_len(
		input logic [2:0] n, input logic [1:0] md);
		if (md == `OVRD_MODE_CPLX)
			win_len = `OVRD_WIN_ONE << n; // [R15]
		else
			// Widen first: setting 7 would wrap a 3-bit sum to 0 [R15]
			win_len = `OVRD_WIN_ONE << ({1'b0, n} + 4'h1);
	endfunction

	function automatic logic is_dec(input logic [1:0] md);
		is_dec = (md == `OVRD_MODE_REAL) || (md == `OVRD_MODE_CPLX);
	endfunction

	function automatic logic [31:0] rd_mux(input ovrd_st_t s,
		input logic [3:0] a, input logic [3:0] pins);
		rd_mux = '0;
		case (a)
			`OVRD_ADDR_CTRL:
			begin
				rd_mux[`OVRD_THR_HI_LSB +: 8] = s.thr_hi;
				rd_mux[`OVRD_THR_LO_LSB +: 8] = s.thr_lo;
				rd_mux[`OVRD_PER_LSB +: 3] = s.per;
				rd_mux[`OVRD_MODE_LSB +: 2] = s.mode;
			end
			`OVRD_ADDR_STAT:
				rd_mux[`OVRD_NFLAG-1:0] = s.status;
			`OVRD_ADDR_MASK:
				rd_mux[`OVRD_NFLAG-1:0] = s.mask;
			`OVRD_ADDR_FLAG:
				rd_mux[`OVRD_NFLAG-1:0] = pins;
			default:
				rd_mux = '0;
		endcase
	endfunction

	// -------------------------------------------------------------
	// Comparison
	// -------------------------------------------------------------
	ovrd_st_t st_r;
	ovrd_st_t st_nxt;
	logic [7:0] mag_a;
	logic [7:0] mag_b;
	logic [`OVRD_NFLAG-1:0] hit;
	logic [`OVRD_NFLAG-1:0] pin_flag;
	logic win_end;

	assign mag_a = abs_mag(SAMPLE_A);
	assign mag_b = abs_mag(SAMPLE_B);

	// Same pair for both channels, each compare on its own [R4] [R17]
	always_comb
	begin
		hit[0] = SAMPLE_VALID && (mag_a >= st_r.thr_hi); // [R7]
		hit[1] = SAMPLE_VALID && (mag_a >= st_r.thr_lo); // [R7]
		hit[2] = SAMPLE_VALID && (mag_b >= st_r.thr_hi); // [R7]
		hit[3] = SAMPLE_VALID && (mag_b >= st_r.thr_lo); // [R7]
	end

	assign win_end = SAMPLE_VALID &&
		(st_r.win_cnt >= win_len(st_r.per, st_r.mode) - `OVRD_WIN_ONE);

	// -------------------------------------------------------------
	// Status pins, one stretcher each
	// -------------------------------------------------------------
	// Order: A high, A low, B high, B low [R8] [R17]
	for (genvar i = 0; i < `OVRD_NFLAG; i++)
	begin : g_str
		ovrd_stretch u_str (
			.clk(CLK_SYS),
			.nrst(NRST),
			.hit(hit[i]),
			.per_sel(st_r.per),
			.flag(pin_flag[i])
		);
	end

	// -------------------------------------------------------------
	// Next state
	// -------------------------------------------------------------
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.rdy = 1'b1;
		st_nxt.resp = 1'b0;
		// Data phase of a write
		if (st_r.ap_wr)
		begin
			case (st_r.ap_addr)
				`OVRD_ADDR_CTRL:
				begin
					st_nxt.thr_hi = HWDATA[`OVRD_THR_HI_LSB +: 8];
					st_nxt.thr_lo = HWDATA[`OVRD_THR_LO_LSB +: 8];
					st_nxt.per = HWDATA[`OVRD_PER_LSB +: 3];
					st_nxt.mode = HWDATA[`OVRD_MODE_LSB +: 2];
				end
				`OVRD_ADDR_STAT:
					st_nxt.status = st_r.status &
						~HWDATA[`OVRD_NFLAG-1:0];
				`OVRD_ADDR_MASK:
					st_nxt.mask = HWDATA[`OVRD_NFLAG-1:0];
				default:
					st_nxt.mask = st_r.mask;
			endcase
		end
		// New events win over a clear in the same cycle
		st_nxt.status = st_nxt.status | hit;
		st_nxt.irq = |(st_r.status & st_r.mask);
		// Address phase; HADDR[3:2] picks one of the four registers, OKAY always
		if (HREADY)
		begin
			st_nxt.ap_wr = HSEL && HTRANS[1] && HWRITE;
			st_nxt.ap_addr = {HADDR[3:2], 2'h0};
			if (HSEL && HTRANS[1] && !HWRITE)
				st_nxt.hrdata = rd_mux(st_r,
					{HADDR[3:2], 2'h0}, pin_flag);
		end
		// Monitoring window for embedded bits [R14] [R15]
		if (win_end)
		begin
			st_nxt.emb = st_r.acc | hit;
			st_nxt.acc = '0;
			st_nxt.win_cnt = '0;
		end
		else if (SAMPLE_VALID)
		begin
			st_nxt.acc = st_r.acc | hit;
			st_nxt.win_cnt = st_r.win_cnt + `OVRD_WIN_ONE;
		end
		// Output samples; phase 0 is even or I, 1 is odd or Q
		st_nxt.dec_v = DEC_VALID_IN;
		if (DEC_VALID_IN)
		begin
			st_nxt.dec_a = DEC_A_IN;
			st_nxt.dec_b = DEC_B_IN;
			// Plain modes pass samples through untouched [R11]
			if (is_dec(st_r.mode))
			begin
				// Same lane choice in real and complex [R12] [R13]
				st_nxt.dec_a[0] = st_r.phase ? st_r.emb[1] : st_r.emb[0];
				st_nxt.dec_b[0] = st_r.phase ? st_r.emb[3] : st_r.emb[2];
				st_nxt.phase = !st_r.phase;
			end
			else
				st_nxt.phase = 1'b0;
		end
	end

	// -------------------------------------------------------------
	// State register
	// -------------------------------------------------------------
	always_ff @(posedge CLK_SYS or negedge NRST)
	begin
		if (!NRST)
		begin
			st_r <= '0;
			st_r.thr_hi <= `OVRD_THR_HI_RST;
			st_r.thr_lo <= `OVRD_THR_LO_RST;
			st_r.per <= `OVRD_PER_RST;
			st_r.mode <= `OVRD_MODE_RST;
			st_r.rdy <= 1'b1;
		end
		else
			st_r <= st_nxt;
	end

	// -------------------------------------------------------------
	// Outputs
	// -------------------------------------------------------------
	assign HREADYOUT = st_r.rdy;
	assign HRESP = st_r.resp;
	assign HRDATA = st_r.hrdata;
	assign IRQ = st_r.irq;
	assign DEC_A_OUT = st_r.dec_a;
	assign DEC_B_OUT = st_r.dec_b;
	assign DEC_VALID_OUT = st_r.dec_v;
	// Single-channel users OR the A and B pins themselves [R9]
	assign CHAN_A_HIGH_FLAG_OUT = pin_flag[0];
	assign CHAN_A_LOW_FLAG_OUT = pin_flag[1];
	assign CHAN_B_HIGH_FLAG_OUT = pin_flag[2];
	assign CHAN_B_LOW_FLAG_OUT = pin_flag[3];

	// -------------------------------------------------------------
	// Checks
	// -------------------------------------------------------------
	property p_sat;
		@(posedge CLK_SYS) disable iff (!NRST)
		SAMPLE_A == `OVRD_NEG_FULL |-> mag_a == `OVRD_MAG_SAT;
	endproperty
	a_sat: assert property (p_sat) // [R5]
		else $error("most negative code not saturated");

	property p_sym;
		@(posedge CLK_SYS) disable iff (!NRST)
		SAMPLE_B != `OVRD_NEG_FULL |-> mag_b == abs_mag(12'(-SAMPLE_B));
	endproperty
	a_sym: assert property (p_sym) // [R6]
		else $error("magnitude differs between +x and -x");

	property p_a_hi;
		@(posedge CLK_SYS) disable iff (!NRST)
		SAMPLE_VALID && mag_a >= st_r.thr_hi |=> CHAN_A_HIGH_FLAG_OUT;
	endproperty
	a_a_hi: assert property (p_a_hi) // [R7]
		else $error("channel A high pin missed a hit");

	property p_b_lo;
		@(posedge CLK_SYS) disable iff (!NRST)
		SAMPLE_VALID && mag_b >= st_r.thr_lo |=> CHAN_B_LOW_FLAG_OUT;
	endproperty
	a_b_lo: assert property (p_b_lo) // [R8]
		else $error("channel B low pin missed a hit");

	property p_quiet;
		@(posedge CLK_SYS) disable iff (!NRST)
		!CHAN_A_LOW_FLAG_OUT && !hit[1] |=> !CHAN_A_LOW_FLAG_OUT;
	endproperty
	a_quiet: assert property (p_quiet) // [R17]
		else $error("channel A low pin rose without a hit");

	property p_emb_i;
		@(posedge CLK_SYS) disable iff (!NRST)
		DEC_VALID_IN && st_r.mode == `OVRD_MODE_CPLX && !st_r.phase
			|=> DEC_A_OUT[0] == $past(st_r.emb[0]) &&
			DEC_A_OUT[15:1] == $past(DEC_A_IN[15:1]);
	endproperty
	a_emb_i: assert property (p_emb_i) // [R12]
		else $error("I sample does not carry high flag");

	property p_emb_odd;
		@(posedge CLK_SYS) disable iff (!NRST)
		DEC_VALID_IN && st_r.mode == `OVRD_MODE_REAL && st_r.phase
			|=> DEC_B_OUT[0] == $past(st_r.emb[3]);
	endproperty
	a_emb_odd: assert property (p_emb_odd) // [R13]
		else $error("odd sample does not carry low flag");

	property p_plain;
		@(posedge CLK_SYS) disable iff (!NRST)
		DEC_VALID_IN && !is_dec(st_r.mode) |=> DEC_A_OUT == $past(DEC_A_IN);
	endproperty
	a_plain: assert property (p_plain) // [R11]
		else $error("sample altered outside decimating modes");

	property p_win;
		@(posedge CLK_SYS) disable iff (!NRST)
		win_end && (hit[0] || st_r.acc[0]) |=> st_r.emb[0];
	endproperty
	a_win: assert property (p_win) // [R14]
		else $error("window hit not embedded");

	property p_irq;
		@(posedge CLK_SYS) disable iff (!NRST)
		hit[0] && st_r.mask[0] |=> ##1 IRQ;
	endproperty
	a_irq: assert property (p_irq)
		else $error("unmasked event gave no interrupt");

endmodule
`default_nettype wire

// [tb/adc_overrange_detector_bench.sv]
// Self-checking bench of the overrange detector top.
// Assumes ovrd_pkg compiled first and ovrd_defines.svh on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "ovrd_defines.svh"

module adc_overrange_detector_bench;
	// ------------------------------
	// Signals
	// ------------------------------
	logic clk, nrst, hsel, hwrite, hreadyout, hresp, sample_valid;
	logic [31:0] haddr, hwdata, hrdata, lf, tmp;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [11:0] sample_a, sample_b;
	logic [15:0] dec_a_in, dec_b_in, dec_a_out, dec_b_out;
	logic dec_valid_in, dec_valid_out, irq, ph;
	logic a_hi, a_lo, b_hi, b_lo, any_hi, any_lo;
	logic [7:0] mg, mb;
	logic [11:0] tbl [8] = '{12'h7FF, 12'h7F0, 12'h000, 12'h810,
		12'h800, 12'h7EF, 12'h808, 12'h400};
	int bad_count, total_checks, n;

	ovrd_top u_dut (.CLK_SYS(clk), .NRST(nrst), .HSEL(hsel),
		.HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
		.HWDATA(hwdata), .HREADY(hreadyout), .HREADYOUT(hreadyout),
		.HRESP(hresp), .HRDATA(hrdata), .SAMPLE_A(sample_a),
		.SAMPLE_B(sample_b), .SAMPLE_VALID(sample_valid),
		.DEC_A_IN(dec_a_in), .DEC_B_IN(dec_b_in),
		.DEC_VALID_IN(dec_valid_in), .DEC_A_OUT(dec_a_out),
		.DEC_B_OUT(dec_b_out), .DEC_VALID_OUT(dec_valid_out),
		.CHAN_A_HIGH_FLAG_OUT(a_hi), .CHAN_A_LOW_FLAG_OUT(a_lo),
		.CHAN_B_HIGH_FLAG_OUT(b_hi), .CHAN_B_LOW_FLAG_OUT(b_lo), .IRQ(irq));

	ovrd_monitor u_mon (.a_high(a_hi), .a_low(a_lo), .b_high(b_hi),
		.b_low(b_lo), .any_high(any_hi), .any_low(any_lo));

	// ------------------------------
	// Helpers
	// ------------------------------
	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	// Saturating magnitude; plain negation of -2048 would wrap back to -2048
	function automatic logic [7:0] mag8(input logic [11:0] s);
		logic [11:0] m;
		m = s[11] ? (~s + 12'h001) : s;
		if (s == 12'h800)
			m = 12'h7FF;
		return m[10:3];
	endfunction

	function automatic logic [31:0] ctrl(input logic [7:0] hi,
		input logic [7:0] lo, input logic [2:0] p, input logic [1:0] md);
		return (32'(hi) << `OVRD_THR_HI_LSB) | (32'(lo) << `OVRD_THR_LO_LSB)
			| (32'(p) << `OVRD_PER_LSB) | (32'(md) << `OVRD_MODE_LSB);
	endfunction

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic ahb(input logic wr, input logic [3:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		// No wait limit here: the watchdog ends a hung bus
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {28'h0, a};
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwrite <= 1'b0;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
		check(32'(hresp), 32'h0);
		hsel <= 1'b0;
	endtask

	task automatic hit(input logic [11:0] a, input logic [11:0] b);
		@(posedge clk);
		sample_a <= a;
		sample_b <= b;
		sample_valid <= 1'b1;
		@(posedge clk);
		sample_valid <= 1'b0;
		#1;
	endtask

	// fa/fb: bit 0 high-threshold flag, bit 1 low-threshold flag
	task automatic dec_chk(input logic pass, input logic [1:0] fa,
		input logic [1:0] fb);
		logic [15:0] da, db;
		lf = lfsr_next(lf);
		da = lf[15:0];
		db = lf[31:16];
		@(posedge clk);
		dec_a_in <= da;
		dec_b_in <= db;
		dec_valid_in <= 1'b1;
		@(posedge clk);
		dec_valid_in <= 1'b0;
		#1;
		check(32'(dec_valid_out), 32'h1);
		check(32'(dec_a_out), 32'({da[15:1], pass ? da[0] : fa[ph]}));
		check(32'(dec_b_out), 32'({db[15:1], pass ? db[0] : fb[ph]}));
		if (!pass)
			ph = ~ph;
	endtask

	task automatic report_and_stop;
		if (bad_count == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Whole run is a few thousand cycles; this leaves wide margin
	initial
	begin
		#3000000;
		bad_count++;
		report_and_stop;
	end

	// ------------------------------
	// Main sequence
	// ------------------------------
	initial
	begin
		{nrst, hsel, hwrite, sample_valid, dec_valid_in, ph} = '0;
		{haddr, hwdata, sample_a, sample_b, dec_a_in, dec_b_in} = '0;
		htrans = 2'h0;
		hsize = 3'h2;
		bad_count = 0;
		total_checks = 0;
		lf = 32'h3146;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		ahb(1'b0, `OVRD_ADDR_CTRL, 32'h0, tmp);
		check(tmp, ctrl(`OVRD_THR_HI_RST, `OVRD_THR_LO_RST, 3'h0, 2'h0));
		ahb(1'b0, `OVRD_ADDR_MASK, 32'h0, tmp);
		check(tmp, 32'h0);
		// Magnitude and threshold compare, table corners then random
		ahb(1'b1, `OVRD_ADDR_CTRL, ctrl(8'hFE, 8'h80, 3'h0, 2'h0), tmp);
		for (int i = 0; i < 16; i++)
		begin
			lf = lfsr_next(lf);
			if (i < 8)
				hit(tbl[i], lf[27:16]);
			else
				hit(lf[11:0], lf[27:16]);
			mg = mag8(sample_a);
			mb = mag8(sample_b);
			check(32'(a_hi), 32'(mg >= 8'hFE));
			check(32'(a_lo), 32'(mg >= 8'h80));
			check(32'({b_hi, b_lo}), 32'({mb >= 8'hFE, mb >= 8'h80}));
			check(32'({any_hi, any_lo}),
				32'({mg >= 8'hFE || mb >= 8'hFE,
				mg >= 8'h80 || mb >= 8'h80}));
			repeat (10) @(posedge clk);
		end
		// Pulse length for every period setting
		for (int p = 0; p < 8; p++)
		begin
			ahb(1'b1, `OVRD_ADDR_CTRL, ctrl(8'hE4, 8'h40, 3'(p), 2'h0), tmp);
			hit(12'h7FF, 12'h000);
			n = 0;
			while (a_hi === 1'b1 && n < 2000)
			begin
				n++;
				@(posedge clk);
				#1;
			end
			check(32'(n), 32'(8 << p));
		end
		// New hit in mid-pulse restarts the count
		ahb(1'b1, `OVRD_ADDR_CTRL, ctrl(8'hE4, 8'h40, 3'h0, 2'h0), tmp);
		hit(12'h7FF, 12'h000);
		repeat (4) @(posedge clk);
		hit(12'h801, 12'h000);
		n = 0;
		while (a_hi === 1'b1 && n < 2000)
		begin
			n++;
			@(posedge clk);
			#1;
		end
		check(32'(n), 32'h8);
		// Sticky status, mask and interrupt
		ahb(1'b1, `OVRD_ADDR_STAT, 32'hF, tmp);
		ahb(1'b0, `OVRD_ADDR_STAT, 32'h0, tmp);
		check(tmp, 32'h0);
		hit(12'h800, 12'h000);
		repeat (10) @(posedge clk);
		ahb(1'b0, `OVRD_ADDR_STAT, 32'h0, tmp);
		check(tmp, 32'h3);
		check(32'(irq), 32'h0);
		ahb(1'b1, `OVRD_ADDR_MASK, 32'h1, tmp);
		repeat (2) @(posedge clk);
		#1;
		check(32'(irq), 32'h1);
		ahb(1'b1, `OVRD_ADDR_STAT, 32'h1, tmp);
		repeat (2) @(posedge clk);
		#1;
		check(32'(irq), 32'h0);
		ahb(1'b0, `OVRD_ADDR_STAT, 32'h0, tmp);
		check(tmp, 32'h2);
		// Embedded flags: A between thresholds, B above both
		@(posedge clk);
		sample_a <= 12'h400;
		sample_b <= 12'h800;
		sample_valid <= 1'b1;
		repeat (10) @(posedge clk);
		ahb(1'b0, `OVRD_ADDR_FLAG, 32'h0, tmp);
		check(tmp, 32'hE);
		dec_chk(1'b1, 2'h0, 2'h0);
		dec_chk(1'b1, 2'h0, 2'h0);
		// Mode 3 is plain too; real mode last, for the clearing case
		for (int md = 3; md > 0; md--)
		begin
			ahb(1'b1, `OVRD_ADDR_CTRL, ctrl(8'hE4, 8'h40, 3'h0, 2'(md)), tmp);
			repeat (10) @(posedge clk);
			for (int k = 0; k < 4; k++)
				dec_chk(md == 3, 2'h2, 2'h3);
		end
		@(posedge clk);
		sample_a <= 12'h000;
		sample_b <= 12'h000;
		repeat (10) @(posedge clk);
		for (int k = 0; k < 2; k++)
			dec_chk(1'b0, 2'h0, 2'h0);
		report_and_stop;
	end
endmodule

`default_nettype wire

// [tb/ovrd_monitor.sv]
// Downstream monitor model of the overrange status pins.
// Assumes the four pins are registered on the same clock as the bench.
`timescale 1ns/1ps
`default_nettype none

module ovrd_monitor
(
	input wire logic a_high,
	input wire logic a_low,
	input wire logic b_high,
	input wire logic b_low,
	output logic any_high,
	output logic any_low
);
	// ------------------------------
	// Single-channel view
	// ------------------------------
	// Either channel may carry the event, so only the OR is meaningful
	always_comb
	begin
		any_high = a_high | b_high;
		any_low = a_low | b_low;
	end
endmodule

`default_nettype wire
